/* File: sim/card_model.sv */
// smart card and connector switch at the card pins
// assumes card line pulled up; switch pull-down when active high
`timescale 1ns/1ns
module card_model
    import card_pin_pkg::*;
(
    input  wire logic card_serial_line_o,
    input  wire logic card_serial_line_oe_b_o,
    input  wire logic card_pulls_low_i,
    input  wire logic inserted_i,
    input  wire logic switch_active_high_i,
    input  wire logic spike_i,
    output logic      card_serial_line_i,
    output logic      card_presence_in_i
);
    // open drain: either side pulls low, else the pull-up wins
    assign card_serial_line_i = !((!card_serial_line_oe_b_o && !card_serial_line_o)
        || card_pulls_low_i);
    assign card_presence_in_i = (switch_active_high_i ? inserted_i : !inserted_i)
        ^ spike_i;
endmodule // card_model

/* File: sim/card_pin_control_props.sv */
// port-level checks for card_pin_control
// assumes pins pass 2 sync flops and an output register, 3 edges in all
`timescale 1ns/1ns
module card_pin_control_props
    import card_pin_pkg::*;
(
    input wire logic             mclk_i,
    input wire logic             rst_b_i,
    input wire logic             sel_clock_i,
    input wire logic             slope_slow_i,
    input wire logic             presence_active_high_i,
    input wire logic             spi_special_mode_i,
    input wire logic             card_active_i,
    input wire supply_state_type supply_i,
    input wire logic             host_reset_i,
    input wire logic             cs_b_i,
    input wire logic             host_io_i,
    input wire logic             card_presence_in_i,
    input wire logic             card_clock_out_o,
    input wire logic             card_clock_slow_o,
    input wire logic             card_reset_out_o,
    input wire logic             card_serial_line_o,
    input wire logic             card_serial_line_oe_b_o,
    input wire logic             host_io_oe_b_o,
    input wire logic             presence_report_bit_o,
    input wire logic             card_inserted_o,
    input wire logic             presence_event_o,
    input wire logic             overload_fault_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    wire logic supply_ok = supply_i.live && !supply_i.startup && !supply_i.overload
        && card_active_i && !overload_fault_o;
    // cycles since the presence pin last moved, saturating
    logic [4:0] stab_reg;
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            stab_reg <= 5'h00;
        else if ($changed(card_presence_in_i))
            stab_reg <= 5'h00;
        else if (stab_reg != 5'h1F)
            stab_reg <= stab_reg + 5'h01;
    end
    a_clock_low_off:
        assert property ((!supply_i.live || supply_i.startup)[*4] |-> !card_clock_out_o)
        else $error("card clock not low with supply down");
    a_clock_follows_sel:
        assert property (supply_ok[*5] |-> card_clock_out_o == $past(sel_clock_i, 3))
        else $error("card clock not following selector");
    a_slope_applied:
        assert property (card_clock_slow_o == $past(slope_slow_i))
        else $error("slope setting not applied");
    a_reset_forced:
        assert property (!card_active_i |=> !card_reset_out_o)
        else $error("card reset not forced low");
    a_reset_follows:
        assert property ((supply_ok && !cs_b_i)[*5] |-> card_reset_out_o == $past(host_reset_i, 3))
        else $error("card reset not following host");
    a_line_low_off:
        assert property ((!supply_i.live || supply_i.startup)[*4]
            |-> !card_serial_line_oe_b_o && !card_serial_line_o)
        else $error("card line not held low");
    a_host_to_card:
        assert property ((supply_ok && !host_io_i && host_io_oe_b_o)[*4]
            |-> !card_serial_line_oe_b_o && !card_serial_line_o)
        else $error("host zero not relayed");
    a_report_normal:
        assert property ((!spi_special_mode_i && $stable(card_inserted_o)
            && $stable(presence_active_high_i))[*2] |-> presence_report_bit_o == card_inserted_o)
        else $error("normal report differs from inserted");
    a_report_special:
        assert property ((spi_special_mode_i && $stable(card_inserted_o)
            && $stable(presence_active_high_i))[*2]
            |-> presence_report_bit_o == (card_inserted_o ~^ presence_active_high_i))
        else $error("special report differs from pin level");
    a_filter_stable:
        assert property ($changed(card_inserted_o) && $stable(presence_active_high_i)
            && presence_active_high_i == $past(presence_active_high_i, 2)
            |-> stab_reg >= 5'(FILTER_CYCLES))
        else $error("presence accepted before filter time");
    a_event_on_change:
        assert property ($changed(card_inserted_o) |-> ##[0:1] presence_event_o)
        else $error("presence change without event");
    a_overload_flag:
        assert property (supply_i.overload[*2] |-> ##[0:4] overload_fault_o)
        else $error("overload not flagged");
endmodule // card_pin_control_props

bind card_pin_control card_pin_control_props props (.*);

/* File: sim/test_card_pin_control.sv */
// self-checking bench for card_pin_control
// assumes 3 edges from a pin to an output, 1 edge per host command
`timescale 1ns/1ns
module test_card_pin_control;
    import card_pin_pkg::*;
    logic mclk_i, rst_b_i, sel_clock_i, slope_slow_i, presence_active_high_i;
    logic spi_special_mode_i, card_active_i, supply_request_i, fault_clear_i;
    logic presence_event_clear_i, host_reset_i, cs_b_i, host_low, card_pulls_low_i;
    logic inserted_i, switch_active_high_i, spike_i, exp_clk;
    supply_state_type supply_i;
    wire logic host_io_i, card_serial_line_i, card_presence_in_i;
    logic card_clock_out_o, card_clock_slow_o, card_reset_out_o, card_serial_line_o;
    logic card_serial_line_oe_b_o, host_io_o, host_io_oe_b_o, presence_report_bit_o;
    logic card_inserted_o, presence_event_o, converter_enable_o, overload_fault_o;
    int err_count, checked, i, pol, mode;
    // host line is open drain as well
    assign host_io_i = !((!host_io_oe_b_o && !host_io_o) || host_low);
    card_pin_control uut (.*);
    card_model card (.*);
    initial
    begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    // selector clock, unrelated phase to mclk_i
    initial
    begin
        sel_clock_i = 1'b0;
        #3;
        forever #80 sel_clock_i = ~sel_clock_i;
    end
    task automatic chk(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        {rst_b_i, slope_slow_i, presence_active_high_i, spi_special_mode_i} = 4'h0;
        {fault_clear_i, presence_event_clear_i, host_reset_i, host_low} = 4'h0;
        {card_pulls_low_i, inserted_i, switch_active_high_i, spike_i} = 4'h0;
        {card_active_i, supply_request_i, cs_b_i} = 3'h7;
        supply_i = 3'h0;
        repeat (12) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        step(6);
        chk(card_clock_out_o, 1'b0);
        chk(card_serial_line_o | card_serial_line_oe_b_o, 1'b0);
        @(posedge mclk_i);
        supply_i <= 3'h6;
        step(30);
        chk(card_clock_out_o, 1'b0);
        chk(card_serial_line_o | card_serial_line_oe_b_o, 1'b0);
        @(posedge mclk_i);
        supply_i <= 3'h2;
        step(6);
        for (i = 0; i < 12; i++)
        begin
            @(posedge mclk_i);
            exp_clk = sel_clock_i;
            step(2);
            chk(card_clock_out_o, exp_clk);
        end
        @(posedge mclk_i);
        slope_slow_i <= 1'b1;
        step(1);
        chk(card_clock_slow_o, 1'b1);
        @(posedge mclk_i);
        {cs_b_i, host_reset_i} <= 2'h1;
        step(4);
        chk(card_reset_out_o, 1'b1);
        @(posedge mclk_i);
        cs_b_i <= 1'b1;
        step(1);
        @(posedge mclk_i);
        host_reset_i <= 1'b0;
        step(4);
        chk(card_reset_out_o, 1'b1);
        @(posedge mclk_i);
        cs_b_i <= 1'b0;
        step(4);
        chk(card_reset_out_o, 1'b0);
        @(posedge mclk_i);
        {card_active_i, host_reset_i} <= 2'h1;
        step(3);
        chk(card_reset_out_o, 1'b0);
        @(posedge mclk_i);
        card_active_i <= 1'b1;
        step(4);
        chk(card_reset_out_o, 1'b1);
        @(posedge mclk_i);
        host_low <= 1'b1;
        step(4);
        chk(card_serial_line_i, 1'b0);
        @(posedge mclk_i);
        host_low <= 1'b0;
        step(12);
        chk(card_serial_line_i, 1'b1);
        @(posedge mclk_i);
        card_pulls_low_i <= 1'b1;
        step(4);
        chk(host_io_i, 1'b0);
        chk(card_serial_line_oe_b_o, 1'b1);
        @(posedge mclk_i);
        {card_pulls_low_i, presence_event_clear_i} <= 2'h1;
        step(12);
        chk(host_io_i, 1'b1);
        chk(card_inserted_o, 1'b0);
        for (pol = 0; pol < 2; pol++)
            for (mode = 0; mode < 2; mode++)
            begin
                @(posedge mclk_i);
                presence_active_high_i <= pol[0];
                switch_active_high_i <= pol[0];
                spi_special_mode_i <= mode[0];
                {inserted_i, presence_event_clear_i} <= 2'h2;
                step(25);
                chk(card_inserted_o, 1'b1);
                chk(presence_report_bit_o, mode[0] ? pol[0] : 1'b1);
                chk(presence_event_o, 1'b1);
                @(posedge mclk_i);
                {spike_i, presence_event_clear_i} <= 2'h3;
                step(7);
                @(posedge mclk_i);
                spike_i <= 1'b0;
                step(25);
                chk(card_inserted_o, 1'b1);
                chk(presence_event_o, 1'b0);
                @(posedge mclk_i);
                {inserted_i, presence_event_clear_i} <= 2'h0;
                step(25);
                chk(card_inserted_o, 1'b0);
                chk(presence_report_bit_o, mode[0] ? !pol[0] : 1'b0);
                chk(presence_event_o, 1'b1);
            end
        @(posedge mclk_i);
        supply_i <= 3'h3;
        step(5);
        chk(overload_fault_o, 1'b1);
        chk(card_reset_out_o, 1'b0);
        chk(converter_enable_o, 1'b1);
        for (i = 0; i < 400 && converter_enable_o; i++)
            step(1);
        chk(i >= 280 && i <= 320, 1'b1);
        if (converter_enable_o)
            finish_test();
        chk(card_clock_out_o | card_serial_line_o | card_serial_line_oe_b_o, 1'b0);
        @(posedge mclk_i);
        {supply_i, fault_clear_i} <= 4'h5;
        step(5);
        chk(overload_fault_o, 1'b0);
        chk(converter_enable_o, 1'b1);
        @(posedge mclk_i);
        supply_request_i <= 1'b0;
        step(2);
        chk(converter_enable_o, 1'b0);
        finish_test();
    end
endmodule // test_card_pin_control

/* File: src/card_pin_control.sv */
// card-side pin logic: card clock, reset, serial line, presence, overload shutdown
// assumes host-side command bits are on mclk_i; all pins and the selector clock
// are asynchronous and pass pin_sync first
//
// What this block does
// - the card clock is held low during supply start-up and while the supply is off.
// - the card clock follows the output of the internal clock selector.
// - the host picks a fast or slow clock edge rate and the block applies it to the clock pin.
// - with no inversion the presence pin idles high and low means a card is inserted.
// - the presence pin is filtered so short spikes do not change the reported state.
// - the host sets the active polarity of the presence switch and the pin is read that way.
// - in normal serial mode the presence report bit is high whenever a card is inserted.
// - in special serial mode the presence report bit copies the presence pin level.
// - the host reset reaches the card reset pin only while chip select is low.
// - the card reset pin is forced low whenever the card is deactivated.
// - serial data is relayed both ways between the host line and the card line.
// - the card serial line is held low during supply start-up and while the supply is off.
// - on supply overload the converter stops, the card pins power down in order, a fault is flagged.
`timescale 1ns/1ns
module card_pin_control
    import card_pin_pkg::*;
(
    input  wire logic             mclk_i,
    input  wire logic             rst_b_i,
    input  wire logic             sel_clock_i,
    input  wire logic             slope_slow_i,
    input  wire logic             presence_active_high_i,
    input  wire logic             spi_special_mode_i,
    input  wire logic             card_active_i,
    input  wire logic             supply_request_i,
    input  wire logic             fault_clear_i,
    input  wire logic             presence_event_clear_i,
    input  wire supply_state_type supply_i,
    input  wire logic             host_reset_i,
    input  wire logic             cs_b_i,
    input  wire logic             host_io_i,
    input  wire logic             card_serial_line_i,
    input  wire logic             card_presence_in_i,
    output logic                  card_clock_out_o,
    output logic                  card_clock_slow_o,
    output logic                  card_reset_out_o,
    output logic                  card_serial_line_o,
    output logic                  card_serial_line_oe_b_o,
    output logic                  host_io_o,
    output logic                  host_io_oe_b_o,
    output logic                  presence_report_bit_o,
    output logic                  card_inserted_o,
    output logic                  presence_event_o,
    output logic                  converter_enable_o,
    output logic                  overload_fault_o
);

    logic [SYNC_W-1:0]     pins_raw;
    logic [SYNC_W-1:0]     pins_s;
    logic                  presence_filt;
    deact_state_type       deact_reg;
    deact_state_type       deact_next;
    logic [STEP_CNT_W-1:0] step_reg;
    io_dir_type            io_reg;
    io_dir_type            io_next;
    pin_drive_type         card_drive_next;
    pin_drive_type         host_drive_next;
    logic                  reset_next;

    assign pins_raw = {card_presence_in_i, supply_i.overload, supply_i.live,
                       supply_i.startup, card_serial_line_i, host_io_i, cs_b_i,
                       host_reset_i, sel_clock_i};

    pin_sync #(
        .W       (SYNC_W),
        .RST_VAL (SYNC_RESET)
    ) u_sync (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .d_i     (pins_raw),
        .q_o     (pins_s)
    );

    wire sel_clk_s   = pins_s[IDX_SEL_CLK];
    wire host_rst_s  = pins_s[IDX_HOST_RST];
    wire cs_b_s      = pins_s[IDX_CS_B];
    wire host_io_s   = pins_s[IDX_HOST_IO];
    wire card_io_s   = pins_s[IDX_CARD_IO];
    wire startup_s   = pins_s[IDX_STARTUP];
    wire live_s      = pins_s[IDX_LIVE];
    wire overload_s  = pins_s[IDX_OVERLOAD];

    presence_filter #(
        .CNT_W   (FILTER_CNT_W),
        .LEN     (FILTER_CYCLES)
    ) u_filter (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .level_i (pins_s[IDX_PRESENCE]),
        .level_o (presence_filt)
    );

    // supply and deactivation decode
    wire power_down   = startup_s | ~live_s;
    wire step_done    = step_reg == STEP_CNT_W'(DEACT_STEP_CYCLES - 1);
    wire seq_rst_low  = deact_reg != ST_ACTIVE;
    wire seq_clk_low  = seq_rst_low && deact_reg != ST_DROP_RST;
    wire seq_io_low   = deact_reg == ST_DROP_IO || deact_reg == ST_OFF;
    wire deactivated  = ~card_active_i | power_down | seq_rst_low;
    wire clock_low    = power_down | seq_clk_low | ~card_active_i;
    wire line_low     = power_down | seq_io_low;

    // presence interpretation; xnor maps pin level to inserted for either polarity
    wire inserted     = presence_filt ~^ presence_active_high_i;
    wire report_bit   = spi_special_mode_i ? presence_filt : inserted;
    wire inserted_chg = inserted != card_inserted_o;

    // overload shutdown walks reset, clock, line low in turn, then drops the supply
    always_comb
    begin
        deact_next = deact_reg;
        case (deact_reg)
            ST_ACTIVE:
            begin
                if (overload_s)
                    deact_next = ST_DROP_RST;
            end
            ST_DROP_RST:
            begin
                if (step_done)
                    deact_next = ST_DROP_CLK;
            end
            ST_DROP_CLK:
            begin
                if (step_done)
                    deact_next = ST_DROP_IO;
            end
            ST_DROP_IO:
            begin
                if (step_done)
                    deact_next = ST_OFF;
            end
            ST_OFF:
            begin
                if (fault_clear_i && !overload_s)
                    deact_next = ST_ACTIVE;
            end
            default:
            begin
                deact_next = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            deact_reg <= ST_ACTIVE;
            step_reg  <= '0;
        end
        else
        begin
            deact_reg <= deact_next;
            step_reg  <= (deact_next != deact_reg) ? '0 : step_reg + STEP_CNT_W'(1);
        end
    end

    // fault flag: a new overload in the clearing cycle keeps it set
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            overload_fault_o <= 1'h0;
        else
            overload_fault_o <= overload_s | (overload_fault_o & ~fault_clear_i);
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            converter_enable_o <= 1'h0;
        else
            converter_enable_o <= supply_request_i && deact_reg != ST_OFF;
    end

    // card clock; the selector clock is sampled, so it must stay well below mclk/2
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            card_clock_out_o  <= PIN_LOW;
            card_clock_slow_o <= 1'h0;
        end
        else
        begin
            card_clock_out_o  <= clock_low ? PIN_LOW : sel_clk_s;
            card_clock_slow_o <= slope_slow_i;
        end
    end

    // card reset: low when deactivated, follows host only with chip select low
    always_comb
    begin
        if (deactivated)
            reset_next = PIN_LOW;
        else if (!cs_b_s)
            reset_next = host_rst_s;
        else
            reset_next = card_reset_out_o;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            card_reset_out_o <= PIN_LOW;
        else
            card_reset_out_o <= reset_next;
    end

    // serial relay: first side to pull low leads; settle stops the echo
    // of our own drive being mistaken for the other side starting
    always_comb
    begin
        io_next = io_reg;
        case (io_reg)
            IO_IDLE:
            begin
                if (!host_io_s)
                    io_next = IO_HOST_LEADS;
                else if (!card_io_s)
                    io_next = IO_CARD_LEADS;
            end
            IO_HOST_LEADS:
            begin
                if (host_io_s)
                    io_next = IO_SETTLE;
            end
            IO_CARD_LEADS:
            begin
                if (card_io_s)
                    io_next = IO_SETTLE;
            end
            IO_SETTLE:
            begin
                if (host_io_s && card_io_s)
                    io_next = IO_IDLE;
            end
            default:
            begin
                io_next = IO_IDLE;
            end
        endcase
        if (line_low)
            io_next = IO_SETTLE;
    end

    always_comb
    begin
        card_drive_next = '{level: LINE_RELEASED, oe_b: 1'h1};
        host_drive_next = '{level: LINE_RELEASED, oe_b: 1'h1};
        if (line_low)
            card_drive_next = '{level: PIN_LOW, oe_b: 1'h0};
        else if (io_next == IO_HOST_LEADS)
            card_drive_next = '{level: PIN_LOW, oe_b: 1'h0};
        if (!line_low && io_next == IO_CARD_LEADS)
            host_drive_next = '{level: PIN_LOW, oe_b: 1'h0};
    end

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            io_reg                  <= IO_SETTLE;
            card_serial_line_o      <= PIN_LOW;
            card_serial_line_oe_b_o <= 1'h0;
            host_io_o               <= LINE_RELEASED;
            host_io_oe_b_o          <= 1'h1;
        end
        else
        begin
            io_reg                  <= io_next;
            card_serial_line_o      <= card_drive_next.level;
            card_serial_line_oe_b_o <= card_drive_next.oe_b;
            host_io_o               <= host_drive_next.level;
            host_io_oe_b_o          <= host_drive_next.oe_b;
        end
    end

    // presence report and change event; a change in the clear cycle wins
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            presence_report_bit_o <= 1'h0;
            card_inserted_o       <= 1'h0;
            presence_event_o      <= 1'h0;
        end
        else
        begin
            presence_report_bit_o <= report_bit;
            card_inserted_o       <= inserted;
            presence_event_o      <= inserted_chg | (presence_event_o & ~presence_event_clear_i);
        end
    end

endmodule // card_pin_control

/* File: src/card_pin_pkg.sv */
// constants, states and carrier types shared by the card pin control design
// assumes a single 100 MHz core clock and asynchronous active-low reset
package card_pin_pkg;

    localparam int unsigned CLK_PERIOD_NS     = 10;
    localparam int unsigned DEACT_STEP_NS     = 1000;
    localparam int unsigned DEACT_STEP_CYCLES =
        (DEACT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STEP_CNT_W        = 8;
    localparam int unsigned FILTER_CYCLES     = 16;
    localparam int unsigned FILTER_CNT_W      = 5;

    // positions in the synchronised pin vector
    localparam int unsigned SYNC_W       = 9;
    localparam int unsigned IDX_SEL_CLK  = 0;
    localparam int unsigned IDX_HOST_RST = 1;
    localparam int unsigned IDX_CS_B     = 2;
    localparam int unsigned IDX_HOST_IO  = 3;
    localparam int unsigned IDX_CARD_IO  = 4;
    localparam int unsigned IDX_STARTUP  = 5;
    localparam int unsigned IDX_LIVE     = 6;
    localparam int unsigned IDX_OVERLOAD = 7;
    localparam int unsigned IDX_PRESENCE = 8;

    // reset values
    localparam logic [SYNC_W-1:0] SYNC_RESET     = 9'h11C;
    localparam logic              PRESENCE_IDLE  = 1'h1;
    localparam logic              LINE_RELEASED  = 1'h1;
    localparam logic              PIN_LOW        = 1'h0;

    typedef struct packed
    {
        logic startup;
        logic live;
        logic overload;
    } supply_state_type;

    typedef struct packed
    {
        logic level;
        logic oe_b;
    } pin_drive_type;

    typedef enum logic [2:0]
    {
        ST_ACTIVE,
        ST_DROP_RST,
        ST_DROP_CLK,
        ST_DROP_IO,
        ST_OFF
    } deact_state_type;

    typedef enum logic [1:0]
    {
        IO_IDLE,
        IO_HOST_LEADS,
        IO_CARD_LEADS,
        IO_SETTLE
    } io_dir_type;

endpackage

/* File: src/pin_sync.sv */
// two-flop synchroniser for a vector of asynchronous pins
// assumes each bit is an independent level; no bus coherence
`timescale 1ns/1ns
module pin_sync
    import card_pin_pkg::*;
#(
    parameter int unsigned          W       = SYNC_W,
    parameter logic [SYNC_W-1:0]    RST_VAL = SYNC_RESET
)
(
    input  wire logic         mclk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta_reg <= RST_VAL[W-1:0];
            q_o      <= RST_VAL[W-1:0];
        end
        else
        begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end

endmodule // pin_sync

/* File: src/presence_filter.sv */
// stability filter for the synchronised card presence level
// assumes its input is already synchronised to mclk_i
`timescale 1ns/1ns
module presence_filter
    import card_pin_pkg::*;
#(
    parameter int unsigned CNT_W = FILTER_CNT_W,
    parameter int unsigned LEN   = FILTER_CYCLES
)
(
    input  wire logic mclk_i,
    input  wire logic rst_b_i,
    input  wire logic level_i,
    output logic      level_o
);

    logic [CNT_W-1:0] cnt_reg;
    wire              differs = level_i != level_o;
    wire              settled = cnt_reg == CNT_W'(LEN - 1);

    // any bounce restarts the count, so spikes shorter than LEN cycles never pass
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_reg <= '0;
            level_o <= PRESENCE_IDLE;
        end
        else if (!differs)
        begin
            cnt_reg <= '0;
        end
        else if (settled)
        begin
            cnt_reg <= '0;
            level_o <= level_i;
        end
        else
        begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

endmodule // presence_filter
